/* hw/wst_timers.sv */
// wake pin qualification, bus silence, sleep-wake-error, dominant timeout and sic timing
`default_nettype none
module wst_timers
    import wst_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int SWE_MS = SWE_MS_DEF
) (
    input  wire logic      ref_clk,
    input  wire logic      rst_b,
    input  wire logic      wake_pin,
    input  wire logic      txd_in,
    input  wire logic      bus_rx,
    input  wire wst_cfg_t  cfg,
    input  wire logic      swe_run,
    input  wire logic      wup_ind,
    output wst_stat_t      stat
);

    typedef struct packed {
        logic [1:0]  wk_s;
        logic [1:0]  tx_s;
        logic [1:0]  bus_s;
        logic        wk_q;
        logic        tx_q;
        logic        bus_q;
        logic [16:0] pre;
        logic        tick;
        logic [11:0] wk_cnt;
        logic [10:0] sil_cnt;
        logic [18:0] swe_cnt;
        logic [2:0]  dto_cnt;
        logic [9:0]  tog_cnt;
        logic [10:0] bias_cnt;
        logic        bias_pend;
        logic [5:0]  sic_cnt;
        wst_sic_t    sic;
        wst_stat_t   st;
    } wst_state_t;

    // idle bus is recessive (high); bias is on out of power-up
    localparam wst_state_t ST_RST = '{
        tx_s:    2'h3,
        bus_s:   2'h3,
        tx_q:    1'b1,
        bus_q:   1'b1,
        sic:     SIC_IDLE,
        st:      '{rxd: 1'b1, bias_on: 1'b1, default: 1'b0},
        default: '0
    };

    wst_state_t st_r;
    wst_state_t st_nxt;

    logic wk;
    logic tx;
    logic bus;
    logic wk_rise;
    logic wk_fall;
    logic tx_rise;
    logic bus_edge;
    logic wk_long;
    logic wk_short;

    assign wk       = st_r.wk_s[1];
    assign tx       = st_r.tx_s[1];
    assign bus      = st_r.bus_s[1];
    assign wk_rise  = wk & ~st_r.wk_q;
    assign wk_fall  = ~wk & st_r.wk_q;
    assign tx_rise  = tx & ~st_r.tx_q;
    assign bus_edge = bus ^ st_r.bus_q;

    // window only counts in window mode
    assign wk_long  = (cfg.wake_mode == WK_MODE_WIN) &&
                      (st_r.wk_cnt > wk_max_ms(cfg.max_sel));
    // in-between band is treated as too short
    assign wk_short = (st_r.wk_cnt <= wk_rej_ms(cfg.min_sel)) ||
                      (st_r.wk_cnt < wk_min_ms(cfg.min_sel));

    always_comb begin
        st_nxt = st_r;

        // two-stage synchronisers, stage one read only by stage two
        st_nxt.wk_s  = {st_r.wk_s[0], wake_pin};
        st_nxt.tx_s  = {st_r.tx_s[0], txd_in};
        st_nxt.bus_s = {st_r.bus_s[0], bus_rx};
        st_nxt.wk_q  = wk;
        st_nxt.tx_q  = tx;
        st_nxt.bus_q = bus;

        // millisecond tick shared by all slow timers
        st_nxt.tick = (st_r.pre == 17'(MS_CYC - 1));
        if (st_nxt.tick) begin
            st_nxt.pre = '0;
        end else begin
            st_nxt.pre = st_r.pre + 17'h1;
        end

        // wake pin pulse width, tick resolution costs up to 1 ms
        st_nxt.st.wake_good = 1'b0;
        st_nxt.st.wake_bad  = 1'b0;
        if (wk_rise) begin
            st_nxt.wk_cnt = '0;
        end else if (wk && st_r.tick && st_r.wk_cnt != 12'hfff) begin
            st_nxt.wk_cnt = st_r.wk_cnt + 12'h1;
        end
        if (wk_fall) begin
            if (wk_short || wk_long) begin
                st_nxt.st.wake_bad = 1'b1;
            end else begin
                st_nxt.st.wake_good = 1'b1;
            end
        end

        // bus silence
        if (bus_edge) begin
            st_nxt.sil_cnt    = '0;
            st_nxt.st.silence = 1'b0;
        end else if (st_r.tick && !st_r.st.silence) begin
            if (st_r.sil_cnt == 11'(SIL_MS - 1)) begin
                st_nxt.st.silence = 1'b1;
                st_nxt.st.bias_on = 1'b0;
            end else begin
                st_nxt.sil_cnt = st_r.sil_cnt + 11'h1;
            end
        end

        // bias restore after a dominant start seen while unbiased
        if (!st_r.st.bias_on && !st_r.bias_pend && bus_edge && !bus) begin
            st_nxt.bias_pend = 1'b1;
            st_nxt.bias_cnt  = '0;
        end else if (st_r.bias_pend) begin
            if (st_r.bias_cnt == 11'(BIAS_CYC - 1)) begin
                st_nxt.bias_pend  = 1'b0;
                st_nxt.st.bias_on = 1'b1;
            end else begin
                st_nxt.bias_cnt = st_r.bias_cnt + 11'h1;
            end
        end

        // sleep-wake-error timer
        if (!swe_run) begin
            st_nxt.swe_cnt        = '0;
            st_nxt.st.swe_expired = 1'b0;
        end else if (st_r.tick && !st_r.st.swe_expired) begin
            if (st_r.swe_cnt == 19'(SWE_MS - 1)) begin
                st_nxt.st.swe_expired = 1'b1;
            end else begin
                st_nxt.swe_cnt = st_r.swe_cnt + 19'h1;
            end
        end

        // dominant timeout; first partial tick makes the span DTO_MS to DTO_MS+1 ms
        if (tx) begin
            st_nxt.dto_cnt = '0;
            st_nxt.st.dto  = 1'b0;
        end else if (st_r.tick && !st_r.st.dto) begin
            if (st_r.dto_cnt == 3'(DTO_MS)) begin
                st_nxt.st.dto = 1'b1;
            end else begin
                st_nxt.dto_cnt = st_r.dto_cnt + 3'h1;
            end
        end
        st_nxt.st.drv_dom = ~tx & ~st_nxt.st.dto;

        // receive output: follows bus, or toggles as wake indication
        if (!wup_ind) begin
            st_nxt.tog_cnt = '0;
            st_nxt.st.rxd  = bus;
        end else if (st_r.tog_cnt == 10'(TOG_CYC - 1)) begin
            st_nxt.tog_cnt = '0;
            st_nxt.st.rxd  = ~st_r.st.rxd;
        end else begin
            st_nxt.tog_cnt = st_r.tog_cnt + 10'h1;
        end

        // signal improvement phases; sync lag of 3 cycles sits inside the limits
        unique case (st_r.sic)
            SIC_IDLE: begin
                if (tx_rise) begin
                    st_nxt.sic     = SIC_ACT;
                    st_nxt.sic_cnt = '0;
                end
            end
            SIC_ACT: begin
                if (!tx) begin
                    st_nxt.sic = SIC_IDLE;
                end else if (st_r.sic_cnt == 6'(ACT_END_CYC - 1)) begin
                    st_nxt.sic = SIC_PAS;
                end else begin
                    st_nxt.sic_cnt = st_r.sic_cnt + 6'h1;
                end
            end
            SIC_PAS: begin
                if (!tx) begin
                    st_nxt.sic = SIC_IDLE;
                end
            end
            default: begin
                st_nxt.sic = SIC_IDLE;
            end
        endcase
        st_nxt.st.act_rec = (st_nxt.sic == SIC_ACT);
        st_nxt.st.pas_rec = (st_nxt.sic == SIC_PAS);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stat = st_r.st;

endmodule
`default_nettype wire

/* hw/wst_pkg.sv */
// package: constants, types and lookups for the wake and bus timing block
`default_nettype none
package wst_pkg;
    localparam int CLK_HZ        = 100_000_000;
    localparam int CLK_NS        = 10;
    localparam int MS_CYC_DEF    = CLK_HZ / 1000;
    // wake pin pulse limits, in ms
    localparam logic [1:0] WK_MODE_WIN = 2'h3;
    localparam int WK_MAX0_MIN_MS = 750;
    localparam int WK_MAX0_MAX_MS = 950;
    localparam int WK_MAX1_MIN_MS = 1000;
    localparam int WK_MAX1_MAX_MS = 1250;
    localparam int WK_MAX2_MIN_MS = 1500;
    localparam int WK_MAX2_MAX_MS = 1875;
    localparam int WK_MAX3_MIN_MS = 2000;
    localparam int WK_MAX3_MAX_MS = 2500;
    localparam int WK_MIN_BASE_MS = 10;
    localparam int WK_REJ_BASE_MS = 5;
    // bus silence, sleep-wake-error, dominant timeout, in ms
    localparam int SIL_MIN_MS    = 600;
    localparam int SIL_MAX_MS    = 1200;
    localparam int SIL_MS        = (SIL_MIN_MS + SIL_MAX_MS) / 2;
    localparam int SWE_MIN_MS    = 225_000;
    localparam int SWE_MAX_MS    = 300_000;
    localparam int SWE_MS_DEF    = (SWE_MIN_MS + SWE_MAX_MS) / 2;
    localparam int DTO_MIN_MS    = 1;
    localparam int DTO_MAX_MS    = 5;
    localparam int DTO_MS        = (DTO_MIN_MS + DTO_MAX_MS) / 2;
    // short timings, time first, cycles derived
    localparam int TOG_NS        = 10_000;
    localparam int TOG_CYC       = TOG_NS / CLK_NS;
    localparam int BIAS_MAX_US   = 250;
    localparam int BIAS_US       = 20;
    localparam int BIAS_CYC      = BIAS_US * 1000 / CLK_NS;
    localparam int ACT_START_NS  = 120;
    localparam int ACT_START_CYC = ACT_START_NS / CLK_NS;
    localparam int ACT_END_NS    = 355;
    localparam int ACT_END_CYC   = (ACT_END_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAS_START_NS  = 530;
    localparam int PAS_START_CYC = PAS_START_NS / CLK_NS;

    typedef struct packed {
        logic [1:0] wake_mode;
        logic [1:0] min_sel;
        logic [1:0] max_sel;
    } wst_cfg_t;

    typedef struct packed {
        logic wake_good;
        logic wake_bad;
        logic silence;
        logic swe_expired;
        logic dto;
        logic drv_dom;
        logic act_rec;
        logic pas_rec;
        logic rxd;
        logic bias_on;
    } wst_stat_t;

    typedef enum logic [2:0] {
        SIC_IDLE = 3'h1,
        SIC_ACT  = 3'h2,
        SIC_PAS  = 3'h4
    } wst_sic_t;

    function automatic logic [11:0] wk_min_ms(input logic [1:0] sel);
        wk_min_ms = 12'(WK_MIN_BASE_MS << sel);
    endfunction

    function automatic logic [11:0] wk_rej_ms(input logic [1:0] sel);
        wk_rej_ms = 12'(WK_REJ_BASE_MS << sel);
    endfunction

    function automatic logic [11:0] wk_max_ms(input logic [1:0] sel);
        case (sel)
            2'h0:    wk_max_ms = 12'((WK_MAX0_MIN_MS + WK_MAX0_MAX_MS) / 2);
            2'h1:    wk_max_ms = 12'((WK_MAX1_MIN_MS + WK_MAX1_MAX_MS) / 2);
            2'h2:    wk_max_ms = 12'((WK_MAX2_MIN_MS + WK_MAX2_MAX_MS) / 2);
            default: wk_max_ms = 12'((WK_MAX3_MIN_MS + WK_MAX3_MAX_MS) / 2);
        endcase
    endfunction
endpackage
`default_nettype wire

/* sim/wst_timers_assertions.sv */
// checker for wake, transmit and bus timing outputs
`default_nettype none
module wst_timers_assertions
    import wst_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF,
    parameter int SWE_MS = SWE_MS_DEF
) (
    input wire logic      ref_clk,
    input wire logic      rst_b,
    input wire logic      wake_pin,
    input wire logic      txd_in,
    input wire logic      bus_rx,
    input wire wst_cfg_t  cfg,
    input wire logic      swe_run,
    input wire logic      wup_ind,
    input wire wst_stat_t stat
);
    logic [5:0]  hi_run_r;
    logic [31:0] lo_run_r;
    logic [10:0] tog_r;
    logic        rxd_q_r;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // high run starts full, and a timeout also fills it: no edge is seen there
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            hi_run_r <= 6'h3f;
            lo_run_r <= 32'h0;
            tog_r    <= 11'h0;
            rxd_q_r  <= 1'b1;
        end else begin
            hi_run_r <= stat.dto ? 6'h3f : !txd_in ? 6'h00 : hi_run_r + 6'(hi_run_r != 6'h3f);
            lo_run_r <= txd_in ? 32'h0 : lo_run_r + 32'h1;
            tog_r    <= (!wup_ind || stat.rxd != rxd_q_r) ? 11'h0 : tog_r + 11'(tog_r != 11'h7ff);
            rxd_q_r  <= stat.rxd;
        end
    end
    AST_ACT_START: assert property (hi_run_r == 6'd12 |-> stat.act_rec)
        else $error("active phase late");
    AST_ACT_HOLD: assert property (hi_run_r inside {[13:35]} |->
            stat.act_rec && !stat.pas_rec)
        else $error("active phase ended early");
    AST_PAS_START: assert property (hi_run_r == 6'd53 |-> stat.pas_rec && !stat.act_rec)
        else $error("passive phase late");
    AST_DTO_LATE: assert property (lo_run_r == 32'(5 * MS_CYC) |-> stat.dto)
        else $error("dominant timeout late");
    AST_DTO_EARLY: assert property ($rose(stat.dto) |-> lo_run_r >= 32'(MS_CYC))
        else $error("dominant timeout early");
    AST_DTO_DRV: assert property (stat.dto |-> !stat.drv_dom ##1 (txd_in || stat.dto))
        else $error("driver not held recessive");
    AST_WAKE_TIME: assert property (stat.wake_good || stat.wake_bad |->
            !$past(wake_pin, 3))
        else $error("wake result without pin fall");
    AST_TOGGLE: assert property (wup_ind |-> tog_r < 11'd1500)
        else $error("receive output not toggling");
    // a toggle seen while the indication was already on must be at least 5 us apart
    AST_TOGGLE_MIN: assert property ($past(wup_ind) && $past(wup_ind, 2) &&
            stat.rxd != rxd_q_r |-> tog_r >= 11'd499)
        else $error("receive output toggling too fast");
    AST_SIL_CLR: assert property ($changed(bus_rx) |-> ##[1:4] !stat.silence)
        else $error("silence kept after bus edge");
endmodule
`default_nettype wire

/* sim/wst_ctrl_model.sv */
// controller model: drives dominant stretches on the transmit line
`default_nettype none
module wst_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [15:0] dom_len,
    output var logic         txd,
    output var logic         busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // no spi pins on this block: the host keeps its own clock limits
    // changes only on the falling edge, so the block never samples a moving line
    initial begin
        txd  = 1'b1;
        busy = 1'b0;
        forever begin
            @(negedge ref_clk);
            if (go) begin
                busy = 1'b1;
                txd  = 1'b0;
                repeat (dom_len) @(negedge ref_clk);
                txd  = 1'b1;
                busy = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/wst_timers_test.sv */
// bench for the wake and bus timing block with a controller model
`default_nettype none
module wst_timers_test
    import wst_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic        ref_clk;
    logic        rst_b;
    logic        wake_pin;
    logic        swe_run;
    logic        wup_ind;
    logic        go;
    logic        busy;
    logic        txd;
    logic [15:0] dom_len;
    wst_cfg_t    cfg;
    wst_stat_t   stat;
    int          n_fail;
    int          total_checks;
    // bus echoes the transmit line, as with a lone node on the wire
    wst_timers #(.MS_CYC(MS), .SWE_MS(20)) dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .wake_pin(wake_pin), .txd_in(txd), .bus_rx(txd),
        .cfg(cfg), .swe_run(swe_run), .wup_ind(wup_ind), .stat(stat));
    wst_ctrl_model ctrl_u (.ref_clk(ref_clk), .go(go), .dom_len(dom_len), .txd(txd), .busy(busy));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic dom(input int n);
        @(negedge ref_clk);
        dom_len <= 16'(n);
        go      <= 1'b1;
        @(posedge busy);
        go <= 1'b0;
        wait (!busy);
    endtask
    task automatic wpulse(input int ms, input logic [1:0] exp);
        int i;
        wake_pin = 1'b1;
        cyc(ms * MS);
        wake_pin = 1'b0;
        for (i = 0; i < 10 && (stat.wake_good | stat.wake_bad) !== 1'b1; i++) cyc(1);
        chk({stat.wake_good, stat.wake_bad}, exp);
        cyc(5);
    endtask
    task automatic t_tog();
        logic r0;
        wup_ind = 1'b1;
        cyc(400);
        r0 = stat.rxd;
        cyc(1100);
        chk(stat.rxd, !r0);
        wup_ind = 1'b0;
    endtask
    task automatic t_dto();
        dom(8);
        chk(stat.dto, 1'b0);
        cyc(5);
        chk(stat.act_rec, 1'b1);
        cyc(50);
        chk({stat.act_rec, stat.pas_rec}, 2'h1);
        dom(60);
        chk({stat.dto, stat.drv_dom}, 2'h2);
        cyc(6);
        chk(stat.dto, 1'b0);
    endtask
    task automatic t_swe();
        swe_run = 1'b1;
        cyc(165);
        chk(stat.swe_expired, 1'b0);
        cyc(70);
        chk(stat.swe_expired, 1'b1);
        swe_run = 1'b0;
    endtask
    task automatic t_sil();
        int i;
        dom(8);
        cyc(5900);
        chk(stat.silence, 1'b0);
        cyc(6000);
        chk({stat.silence, stat.bias_on}, 2'h2);
        dom(600);
        chk(stat.silence, 1'b0);
        cyc(600);
        dom(600);
        for (i = 0; i < 23000 && stat.bias_on !== 1'b1; i++) cyc(1);
        chk(stat.bias_on, 1'b1);
    endtask
    task automatic t_wake();
        int s;
        int mx[4] = '{960, 1260, 1880, 2510};
        for (s = 0; s < 4; s++) begin
            cfg.min_sel = 2'(s);
            wpulse((10 << s) + 2, 2'h2);
            wpulse(5 << s, 2'h1);
        end
        cfg.min_sel = 2'h0;
        wpulse(960, 2'h2);
        cfg.wake_mode = WK_MODE_WIN;
        wpulse(740, 2'h2);
        for (s = 0; s < 4; s++) begin
            cfg.max_sel = 2'(s);
            wpulse(mx[s], 2'h1);
        end
    endtask
    initial begin
        n_fail = 0;
        total_checks = 0;
        rst_b = 1'b0;
        wake_pin = 1'b0;
        swe_run = 1'b0;
        wup_ind = 1'b0;
        go = 1'b0;
        dom_len = 16'h0000;
        cfg = '0;
        cyc(6);
        chk(16'(stat), 16'h0003);
        rst_b = 1'b1;
        cyc(4);
        t_tog();
        t_dto();
        t_swe();
        t_sil();
        t_wake();
        print_verdict();
    end
    // long enough for all wake windows at the shortened tick
    initial begin
        repeat (104000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end
endmodule
bind wst_timers wst_timers_assertions #(.MS_CYC(MS_CYC), .SWE_MS(SWE_MS)) chk_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .wake_pin(wake_pin), .txd_in(txd_in), .bus_rx(bus_rx),
    .cfg(cfg), .swe_run(swe_run), .wup_ind(wup_ind), .stat(stat));
`default_nettype wire
